/* tmr_ctl_top.sv */
// Timer control block with AHB-Lite register slave and two halves
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module tmr_ctl_top
	import tmr_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic dbg_halted,
	input wire logic event_a,
	input wire logic event_b,
	input wire logic rtc_tick,
	output logic pwm_out,
	output logic adc_trigger
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [3:0] cfg;
	logic [3:0] next_cfg;
	logic [8:0] ctl;
	logic [8:0] next_ctl;
	logic [WIDTH-1:0] load_a;
	logic [WIDTH-1:0] next_load_a;
	logic [WIDTH-1:0] load_b;
	logic [WIDTH-1:0] next_load_b;
	logic [WIDTH-1:0] match_a;
	logic [WIDTH-1:0] next_match_a;
	logic wr_pend;
	logic next_wr_pend;
	logic [11:0] wr_addr;
	logic [11:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic next_pwm;
	logic next_trigger;
	logic [WIDTH-1:0] cnt_a;
	logic [WIDTH-1:0] cnt_b;
	logic tmo_a;
	logic tmo_b;
	logic run_a;
	logic run_b;
	logic stall_a;
	logic addr_phase;
	tmr_mode_t mode_a;
	tmr_mode_t mode_b;
	tmr_edge_t edge_a;

	assign addr_phase = hsel && htrans[1] && hready;
	assign mode_a = tmr_mode_t'(cfg[CFG_A_MODE +: 2]);
	assign mode_b = tmr_mode_t'(cfg[CFG_B_MODE +: 2]);
	assign edge_a = tmr_edge_t'(ctl[CTL_A_EDGE +: 2]);
	// Real-time mode also needs its count enable
	assign run_a = ctl[CTL_A_RUN] && (mode_a != TMR_MODE_RTC || ctl[CTL_RTC_EN]);
	assign run_b = ctl[CTL_B_RUN];
	assign stall_a = ctl[CTL_A_STALL] && dbg_halted;

	// Zero-extend a count to a bus word
	function automatic logic [31:0] tmr_word(input logic [WIDTH-1:0] v);
		tmr_word = 32'(v);
	endfunction

	// Word-aligned register offset of a bus address
	function automatic logic [11:0] tmr_reg_offset(input logic [31:0] addr);
		tmr_reg_offset = {addr[11:2], 2'b00};
	endfunction

	// ----------------------------------------------------------------
	// Bus slave: write in data phase, read data registered at address
	// ----------------------------------------------------------------
	always_comb begin
		next_cfg = cfg;
		next_ctl = ctl;
		next_load_a = load_a;
		next_load_b = load_b;
		next_match_a = match_a;
		next_wr_pend = addr_phase && hwrite;
		next_wr_addr = tmr_reg_offset(haddr);
		if (wr_pend) begin
			case (wr_addr)
				ADDR_CFG: next_cfg = hwdata[3:0];
				ADDR_CTL: next_ctl = hwdata[8:0] & CTL_WR_MASK;
				ADDR_LOAD_A: next_load_a = hwdata[WIDTH-1:0];
				ADDR_LOAD_B: next_load_b = hwdata[WIDTH-1:0];
				ADDR_MATCH_A: next_match_a = hwdata[WIDTH-1:0];
				default: next_cfg = cfg;
			endcase
		end
		// Read mux sees a write still in its data phase
		next_hrdata = 32'h0000_0000;
		if (addr_phase && !hwrite) begin
			case (tmr_reg_offset(haddr))
				ADDR_CFG: next_hrdata = 32'(next_cfg);
				ADDR_CTL: next_hrdata = 32'(next_ctl);
				ADDR_LOAD_A: next_hrdata = tmr_word(next_load_a);
				ADDR_LOAD_B: next_hrdata = tmr_word(next_load_b);
				ADDR_MATCH_A: next_hrdata = tmr_word(next_match_a);
				ADDR_CNT_A: next_hrdata = tmr_word(cnt_a);
				ADDR_CNT_B: next_hrdata = tmr_word(cnt_b);
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg <= CFG_RESET;
			ctl <= CTL_RESET;
			load_a <= '0;
			load_b <= '0;
			match_a <= '0;
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			cfg <= next_cfg;
			ctl <= next_ctl;
			load_a <= next_load_a;
			load_b <= next_load_b;
			match_a <= next_match_a;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Timer halves
	// ----------------------------------------------------------------
	tmr_half #(
		.WIDTH(WIDTH)
	) u_half_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.run_enable(run_a),
		.stall(stall_a),
		.mode(mode_a),
		.edge_select(edge_a),
		.event_in(event_a),
		.tick_in(rtc_tick),
		.load_value(load_a),
		.count(cnt_a),
		.timeout(tmo_a)
	);

	// Half B has no stall control here and captures rising edges
	tmr_half #(
		.WIDTH(WIDTH)
	) u_half_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.run_enable(run_b),
		.stall(1'b0),
		.mode(mode_b == TMR_MODE_RTC ? TMR_MODE_OFF : mode_b),
		.edge_select(TMR_EDGE_RISE),
		.event_in(event_b),
		.tick_in(1'b0),
		.load_value(load_b),
		.count(cnt_b),
		.timeout(tmo_b)
	);

	// ----------------------------------------------------------------
	// Outputs: PWM level and converter trigger
	// ----------------------------------------------------------------
	always_comb begin
		next_pwm = ((cnt_a > match_a) && ctl[CTL_A_RUN]) ^ ctl[CTL_A_PWM_INV];
		next_trigger = tmo_a && ctl[CTL_A_TRIG];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_out <= 1'b0;
			adc_trigger <= 1'b0;
		end else begin
			pwm_out <= next_pwm;
			adc_trigger <= next_trigger;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_b_idle_quiet: assert property ((!ctl[CTL_B_RUN])[*2] |-> !tmo_b)
		else $error("half B timed out while disabled");

	a_b_counts_down: assert property (run_b ##1 (run_b && mode_b == TMR_MODE_PERIODIC
		&& cnt_b != '0) |=> cnt_b == $past(cnt_b) - 1'b1)
		else $error("half B did not count down while enabled");

	a_b_edge_rise: assert property (run_b ##1 (run_b && mode_b == TMR_MODE_CAPTURE
		&& $rose(event_b)) |=> cnt_b == $past(cnt_b) + 1'b1)
		else $error("half B missed a rising edge");

	// A disabled capture half sits at zero
	a_b_idle_zero: assert property ((!run_b && mode_b != TMR_MODE_PERIODIC)[*3]
		|-> cnt_b == '0)
		else $error("idle half B count not zero");

	a_rsvd_reads_zero: assert property (addr_phase && !hwrite
		&& tmr_reg_offset(haddr) == ADDR_CTL |=> hrdata[CTL_RSVD] == 1'b0 && !ctl[CTL_RSVD])
		else $error("reserved control bit not zero");

	a_ctl_write_land: assert property (wr_pend && wr_addr == ADDR_CTL
		|=> !ctl[CTL_RSVD] && ctl[CTL_B_RUN] == $past(hwdata[CTL_B_RUN]))
		else $error("control write landed wrongly");

	a_pwm_idle_level: assert property ((!ctl[CTL_A_RUN] && $stable(ctl))[*2]
		|-> pwm_out == ctl[CTL_A_PWM_INV])
		else $error("idle PWM level wrong for polarity");

	a_pwm_high_level: assert property (ctl[CTL_A_RUN] && cnt_a > match_a
		|=> pwm_out == !$past(ctl[CTL_A_PWM_INV]))
		else $error("running PWM level wrong for polarity");

	a_trig_blocked: assert property ((!ctl[CTL_A_TRIG])[*2] |-> !adc_trigger)
		else $error("trigger issued while disabled");

	a_trig_issued: assert property (tmo_a && ctl[CTL_A_TRIG] |=> adc_trigger)
		else $error("enabled timeout gave no converter trigger");

	a_trig_from_timeout: assert property (adc_trigger |-> $past(tmo_a))
		else $error("converter trigger without a timeout");

	// A gated real-time half drops to idle and clears its count
	a_rtc_gated: assert property ((mode_a == TMR_MODE_RTC && !ctl[CTL_RTC_EN])[*3]
		|-> cnt_a == '0)
		else $error("real-time count moved while disabled");

	a_rtc_tick_count: assert property (run_a && !stall_a ##1 (run_a && !stall_a
		&& mode_a == TMR_MODE_RTC && rtc_tick && cnt_a != load_a)
		|=> cnt_a == $past(cnt_a) + 1'b1)
		else $error("real-time tick not counted");

	a_edge_rise_count: assert property (run_a && !stall_a ##1 (run_a && !stall_a
		&& mode_a == TMR_MODE_CAPTURE && edge_a == TMR_EDGE_RISE && $rose(event_a))
		|=> cnt_a == $past(cnt_a) + 1'b1)
		else $error("rising edge not counted");

	a_edge_fall_count: assert property (run_a && !stall_a ##1 (run_a && !stall_a
		&& mode_a == TMR_MODE_CAPTURE && edge_a == TMR_EDGE_FALL && $fell(event_a))
		|=> cnt_a == $past(cnt_a) + 1'b1)
		else $error("falling edge not counted");

	a_edge_both_count: assert property (run_a && !stall_a ##1 (run_a && !stall_a
		&& mode_a == TMR_MODE_CAPTURE && edge_a == TMR_EDGE_BOTH && $changed(event_a))
		|=> cnt_a == $past(cnt_a) + 1'b1)
		else $error("edge not counted in both-edge mode");

	a_edge_rsvd_none: assert property ((run_a && mode_a == TMR_MODE_CAPTURE
		&& edge_a == TMR_EDGE_RSVD)[*3] |-> $stable(cnt_a))
		else $error("reserved edge select counted an event");

	a_stall_freeze: assert property (ctl[CTL_A_RUN] && ctl[CTL_A_STALL] && dbg_halted
		|=> cnt_a == $past(cnt_a) && !tmo_a)
		else $error("half A moved while stalled");

	a_stall_resume: assert property ($fell(stall_a) && run_a ##1 (run_a && !stall_a
		&& mode_a == TMR_MODE_PERIODIC && cnt_a != '0) |=> cnt_a == $past(cnt_a) - 1'b1)
		else $error("half A did not resume after the halt");

	a_a_counts_down: assert property (run_a && !stall_a ##1 (run_a && !stall_a
		&& mode_a == TMR_MODE_PERIODIC && cnt_a != '0) |=> cnt_a == $past(cnt_a) - 1'b1)
		else $error("half A did not count down while enabled");

	a_a_idle_load: assert property ((!run_a && mode_a == TMR_MODE_PERIODIC
		&& $stable(load_a))[*3] |-> cnt_a == load_a)
		else $error("idle half A does not hold its load value");

	a_a_idle_quiet: assert property ((!run_a)[*2] |-> !tmo_a)
		else $error("half A timed out while disabled");

	a_ctl_reset_zero: assert property (@(posedge hclk) hresetn && !$past(hresetn)
		|-> ctl == 9'h000 && !pwm_out && !adc_trigger)
		else $error("control not zero after reset");

	// Main scenarios reached by the bench
	c_trigger_seen: cover property (adc_trigger);
	c_b_capture: cover property (run_b && mode_b == TMR_MODE_CAPTURE && $rose(event_b));
	c_stall_held: cover property (stall_a && run_a ##1 stall_a ##1 !stall_a);
	c_pwm_toggle: cover property (run_a && $rose(pwm_out));
	c_capture_both: cover property (mode_a == TMR_MODE_CAPTURE && edge_a == TMR_EDGE_BOTH
		&& $fell(event_a));

endmodule // tmr_ctl_top

/* tmr_pkg.sv */
// Constants, types and helpers shared by the timer control block
// How it works
// - Half B run bit 8 idles or starts
// - Control bit 7 reads zero, ignores writes
// - Half A PWM invert bit 6 flips output
// - Half A trigger enable bit 5 gates trigger
// - RTC enable bit gates real-time counting
// - Edge select: rising, falling, both; 2 reserved
// - Half A stall enable permits debug stalling
// - Half A run bit idles or starts
// - Enabled trigger drives the converter start output
// - Control register resets to all zeros
package tmr_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CFG = 12'h000;
	localparam logic [11:0] ADDR_CTL = 12'h00C;
	localparam logic [11:0] ADDR_LOAD_A = 12'h028;
	localparam logic [11:0] ADDR_LOAD_B = 12'h02C;
	localparam logic [11:0] ADDR_MATCH_A = 12'h030;
	localparam logic [11:0] ADDR_CNT_A = 12'h048;
	localparam logic [11:0] ADDR_CNT_B = 12'h04C;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTL_A_RUN = 0;
	localparam int CTL_A_STALL = 1;
	localparam int CTL_A_EDGE = 2;
	localparam int CTL_RTC_EN = 4;
	localparam int CTL_A_TRIG = 5;
	localparam int CTL_A_PWM_INV = 6;
	localparam int CTL_RSVD = 7;
	localparam int CTL_B_RUN = 8;
	localparam logic [8:0] CTL_RESET = 9'h000;
	localparam logic [8:0] CTL_WR_MASK = 9'h17F;

	// ----------------------------------------------------------------
	// Configuration register fields
	// ----------------------------------------------------------------
	localparam int CFG_A_MODE = 0;
	localparam int CFG_B_MODE = 2;
	localparam logic [3:0] CFG_RESET = 4'h0;

	typedef enum logic [1:0] {
		TMR_EDGE_RISE = 2'b00,
		TMR_EDGE_FALL = 2'b01,
		TMR_EDGE_RSVD = 2'b10,
		TMR_EDGE_BOTH = 2'b11
	} tmr_edge_t;

	typedef enum logic [1:0] {
		TMR_MODE_PERIODIC = 2'b00,
		TMR_MODE_CAPTURE = 2'b01,
		TMR_MODE_RTC = 2'b10,
		TMR_MODE_OFF = 2'b11
	} tmr_mode_t;

	typedef enum logic [1:0] {
		TMR_ST_IDLE = 2'b00,
		TMR_ST_RUN = 2'b01,
		TMR_ST_FROZEN = 2'b10
	} tmr_state_t;

	// Selected edge seen on the event input
	function automatic logic tmr_edge_hit(input tmr_edge_t sel, input logic rise,
		input logic fall);
		case (sel)
			TMR_EDGE_RISE: tmr_edge_hit = rise;
			TMR_EDGE_FALL: tmr_edge_hit = fall;
			TMR_EDGE_BOTH: tmr_edge_hit = rise | fall;
			default: tmr_edge_hit = 1'b0;
		endcase
	endfunction

endpackage

/* tmr_half.sv */
// One timer half: periodic, capture edge count or real-time count
`timescale 1ns/10ps
module tmr_half
	import tmr_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run_enable,
	input wire logic stall,
	input wire tmr_mode_t mode,
	input wire tmr_edge_t edge_select,
	input wire logic event_in,
	input wire logic tick_in,
	input wire logic [WIDTH-1:0] load_value,
	output logic [WIDTH-1:0] count,
	output logic timeout
);

	tmr_state_t state;
	tmr_state_t next_state;
	logic [WIDTH-1:0] next_count;
	logic next_timeout;
	logic event_prev;
	logic hit;

	assign hit = tmr_edge_hit(edge_select, event_in & ~event_prev, ~event_in & event_prev);

	// ----------------------------------------------------------------
	// Counter next state
	// ----------------------------------------------------------------
	always_comb begin
		next_count = count;
		next_timeout = 1'b0;
		if (!run_enable) begin
			next_state = TMR_ST_IDLE;
		end else if (stall) begin
			next_state = TMR_ST_FROZEN;
		end else begin
			next_state = TMR_ST_RUN;
		end
		case (state)
			TMR_ST_IDLE: begin
				next_count = (mode == TMR_MODE_PERIODIC) ? load_value : '0;
			end
			TMR_ST_RUN: begin
				if (run_enable && !stall) begin
					case (mode)
						TMR_MODE_PERIODIC: begin
							if (count == '0) begin
								next_count = load_value;
								next_timeout = 1'b1;
							end else begin
								next_count = count - 1'b1;
							end
						end
						TMR_MODE_CAPTURE: begin
							if (hit) begin
								next_count = count + 1'b1;
							end
						end
						TMR_MODE_RTC: begin
							if (tick_in && count == load_value) begin
								next_count = '0;
								next_timeout = 1'b1;
							end else if (tick_in) begin
								next_count = count + 1'b1;
							end
						end
						default: begin
							next_count = count;
						end
					endcase
				end
			end
			default: begin
				next_count = count;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= TMR_ST_IDLE;
			count <= '0;
			timeout <= 1'b0;
			event_prev <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			timeout <= next_timeout;
			event_prev <= event_in;
		end
	end

endmodule // tmr_half

/* tmr_ctl_top_tb_top.sv */
// Self-checking bench for the timer control block over its register bus
`timescale 1ns/10ps
module tmr_ctl_top_tb_top;
	import tmr_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus and observation signals
	// ----------------------------------------------------------------
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic dbg_halted = 1'b0;
	logic event_a = 1'b0;
	logic event_b = 1'b0;
	logic rtc_tick = 1'b0;
	logic pwm_out;
	logic adc_trigger;
	int n_fail = 0;
	int checks_done = 0;

	always #12.5 hclk = ~hclk;

	tmr_ctl_top #(.WIDTH(16)) dut_u (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.dbg_halted(dbg_halted),
		.event_a(event_a),
		.event_b(event_b),
		.rtc_tick(rtc_tick),
		.pwm_out(pwm_out),
		.adc_trigger(adc_trigger)
	);

	// ----------------------------------------------------------------
	// Common tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Waits for an edge with hready high; a hang ends the run
	task automatic wait_rdy();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1) begin
			n_fail++;
			close_out();
		end
	endtask

	task automatic bus_write(input logic [11:0] addr, input logic [31:0] data);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, addr};
		htrans <= 2'b10;
		hwrite <= 1'b1;
		wait_rdy();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= data;
		wait_rdy();
	endtask

	task automatic bus_read(input logic [11:0] addr, output logic [31:0] data);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, addr};
		htrans <= 2'b10;
		hwrite <= 1'b0;
		wait_rdy();
		htrans <= 2'b00;
		hsel <= 1'b0;
		wait_rdy();
		data = hrdata;
	endtask

	task automatic read_check(input logic [11:0] addr, input logic [31:0] exp);
		logic [31:0] v;
		bus_read(addr, v);
		check(v, exp);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sc_reset_and_masks();
		check({29'h0, pwm_out, adc_trigger, hresp}, 32'h0);
		read_check(ADDR_CTL, 32'h0);
		bus_write(ADDR_CTL, 32'hFFFFFFFF);
		read_check(ADDR_CTL, 32'h0000017F);
		bus_write(12'h100, 32'hFFFFFFFF);
		read_check(12'h100, 32'h0);
		bus_write(ADDR_CTL, 32'h0);
		read_check(ADDR_CTL, 32'h0);
	endtask

	task automatic sc_trigger();
		logic found;
		int pulses;
		bus_write(ADDR_CFG, 32'h0);
		bus_write(ADDR_LOAD_A, 32'h2);
		bus_write(ADDR_LOAD_B, 32'h3);
		bus_write(ADDR_CTL, 32'h121);
		found = 1'b0;
		for (int i = 0; i < 20 && !found; i++) begin
			@(posedge hclk);
			if (adc_trigger === 1'b1) found = 1'b1;
		end
		check({31'h0, found}, 32'h1);
		bus_write(ADDR_CTL, 32'h01);
		// A pulse launched before the write may still stand for one edge
		@(posedge hclk);
		pulses = 0;
		repeat (20) begin
			@(posedge hclk);
			if (adc_trigger !== 1'b0) pulses++;
		end
		check(pulses, 32'h0);
		bus_write(ADDR_CTL, 32'h0);
	endtask

	task automatic sc_pwm_invert();
		bus_write(ADDR_LOAD_A, 32'h100);
		bus_write(ADDR_MATCH_A, 32'h0);
		bus_write(ADDR_CTL, 32'h01);
		repeat (3) @(posedge hclk);
		check({31'h0, pwm_out}, 32'h1);
		bus_write(ADDR_CTL, 32'h41);
		repeat (3) @(posedge hclk);
		check({31'h0, pwm_out}, 32'h0);
		bus_write(ADDR_CTL, 32'h40);
		repeat (3) @(posedge hclk);
		check({31'h0, pwm_out}, 32'h1);
		bus_write(ADDR_CTL, 32'h0);
		repeat (3) @(posedge hclk);
		check({31'h0, pwm_out}, 32'h0);
	endtask

	task automatic sc_stall();
		logic [31:0] v1;
		logic [31:0] v2;
		bus_write(ADDR_LOAD_A, 32'h100);
		bus_write(ADDR_CTL, 32'h03);
		repeat (5) @(posedge hclk);
		dbg_halted <= 1'b1;
		repeat (3) @(posedge hclk);
		bus_read(ADDR_CNT_A, v1);
		repeat (5) @(posedge hclk);
		bus_read(ADDR_CNT_A, v2);
		check(v2, v1);
		dbg_halted <= 1'b0;
		repeat (3) @(posedge hclk);
		bus_read(ADDR_CNT_A, v2);
		check({31'h0, v2 != v1}, 32'h1);
		bus_write(ADDR_CTL, 32'h01);
		dbg_halted <= 1'b1;
		bus_read(ADDR_CNT_A, v1);
		bus_read(ADDR_CNT_A, v2);
		check({31'h0, v2 != v1}, 32'h1);
		dbg_halted <= 1'b0;
		bus_write(ADDR_CTL, 32'h0);
	endtask

	// Both halves in capture; half B enabled only for odd edge codes
	task automatic sc_edges();
		logic [31:0] exp_a [4] = '{32'h1, 32'h1, 32'h0, 32'h2};
		bus_write(ADDR_CFG, 32'h5);
		for (int s = 0; s < 4; s++) begin
			bus_write(ADDR_CTL, 32'h0);
			bus_write(ADDR_CTL, {23'h0, s[0], 4'h0, s[1:0], 2'b01});
			repeat (3) @(posedge hclk);
			event_a <= 1'b1;
			event_b <= 1'b1;
			repeat (4) @(posedge hclk);
			event_a <= 1'b0;
			event_b <= 1'b0;
			repeat (4) @(posedge hclk);
			read_check(ADDR_CNT_A, exp_a[s]);
			read_check(ADDR_CNT_B, {31'h0, s[0]});
		end
		bus_write(ADDR_CTL, 32'h0);
	endtask

	task automatic rtc_pulses();
		repeat (3) begin
			@(posedge hclk);
			rtc_tick <= 1'b1;
			@(posedge hclk);
			rtc_tick <= 1'b0;
			@(posedge hclk);
		end
	endtask

	task automatic sc_rtc();
		bus_write(ADDR_CFG, 32'h2);
		bus_write(ADDR_LOAD_A, 32'h5);
		bus_write(ADDR_CTL, 32'h01);
		rtc_pulses();
		read_check(ADDR_CNT_A, 32'h0);
		bus_write(ADDR_CTL, 32'h11);
		rtc_pulses();
		read_check(ADDR_CNT_A, 32'h3);
		bus_write(ADDR_CTL, 32'h0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		sc_reset_and_masks();
		sc_trigger();
		sc_pwm_invert();
		sc_stall();
		sc_edges();
		sc_rtc();
		close_out();
	end

endmodule // tmr_ctl_top_tb_top
